// ---- rtl/uart_baud_bit_timing.sv ----
// serial port with programmable divisor and 15 to 17 ticks per bit, AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module uart_baud_bit_timing #(
  parameter int unsigned divisor_bits = baud_pkg::divisor_width
) (
  input wire clk,
  input wire reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] src_ticks,
  output logic txd,
  input wire logic rxd
);
  import baud_pkg::*;

  logic [7:0] ctl1_reg, ctl1_next;
  logic [2:0] ctl2_reg, ctl2_next;
  logic [7:0] divisor_reg, divisor_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_full_reg, rx_full_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] rd_addr_reg, rd_addr_next;
  logic tx_go, rx_take;

  frame_state_t tx_st_reg, tx_st_next, rx_st_reg, rx_st_next;
  logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic tx_stop2_reg, tx_stop2_next, rx_stop2_reg, rx_stop2_next;
  logic tx_par_reg, tx_par_next;
  logic txd_reg, txd_next;
  logic rxd_prev_reg;
  logic tx_restart, rx_restart;
  logic tx_tick, tx_sample, tx_bit_end, rx_tick, rx_sample, rx_bit_end;
  logic src_sel;

  // source select picks one of four source strobes; index 0 is the system clock
  always_comb begin
    unique case (ctl1_reg[ctl1_src_hi:ctl1_src_lo])
      2'h0: src_sel = 1'b1;
      2'h1: src_sel = src_ticks[0];
      2'h2: src_sel = src_ticks[1];
      default: src_sel = src_ticks[2];
    endcase
  end

  // one settings bundle feeds both timers so both paths share a bit width
  bit_timing_if tim_if ();
  assign tim_if.divisor = divisor_reg;
  assign tim_if.tick_select = ctl2_reg;
  assign tim_if.src_tick = src_sel;

  bit_timer tx_timer (
    .clk(clk), .reset(reset), .cfg(tim_if), .restart(tx_restart),
    .tick(tx_tick), .sample(tx_sample), .bit_end(tx_bit_end)
  );
  bit_timer rx_timer (
    .clk(clk), .reset(reset), .cfg(tim_if), .restart(rx_restart),
    .tick(rx_tick), .sample(rx_sample), .bit_end(rx_bit_end)
  );

  // ahb-lite slave: zero wait states, writes land in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign tx_go = wr_pend_reg && wr_addr_reg == off_tx_data && tx_st_reg == st_idle
    && ctl1_reg[ctl1_tx_enable];
  assign rx_take = rd_pend_reg && rd_addr_reg == off_rx_data;

  always_comb begin
    ctl1_next = ctl1_reg;
    ctl2_next = ctl2_reg;
    divisor_next = divisor_reg;
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    rd_pend_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    rdata_next = rdata_reg;
    if (hready && hsel && htrans[1]) begin
      wr_pend_next = hwrite;
      rd_pend_next = !hwrite;
      wr_addr_next = haddr[7:0];
      rd_addr_next = haddr[7:0];
      // read data is prepared for the following data phase
      unique case (haddr[7:0])
        off_control_one: rdata_next = {24'h000000, ctl1_reg};
        off_control_two: rdata_next = {29'h00000000, ctl2_reg};
        off_divisor: rdata_next = {24'h000000, divisor_reg};
        off_status: rdata_next = {29'h00000000, rx_full_reg, rx_st_reg != st_idle,
          tx_st_reg != st_idle};
        off_rx_data: rdata_next = {24'h000000, rx_data_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        off_control_one: ctl1_next = {1'b0, hwdata[6:0]};
        off_control_two: ctl2_next = hwdata[2:0];
        off_divisor: divisor_next = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl1_reg <= 8'h00;
      ctl2_reg <= sel_16;
      divisor_reg <= divisor_reset;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else begin
      ctl1_reg <= ctl1_next;
      ctl2_reg <= ctl2_next;
      divisor_reg <= divisor_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // transmit framer; a write while busy is dropped
  assign tx_restart = tx_go;
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_stop2_next = tx_stop2_reg;
    tx_par_next = tx_par_reg;
    txd_next = txd_reg;
    unique case (tx_st_reg)
      st_idle: begin
        txd_next = 1'b1;
        if (tx_go) begin
          tx_sh_next = hwdata[7:0];
          tx_par_next = (^hwdata[7:0]) ^ ctl1_reg[ctl1_parity_odd];
          tx_stop2_next = ctl1_reg[ctl1_stop_length];
          txd_next = 1'b0;
          tx_st_next = st_start;
        end
      end
      st_start: if (tx_bit_end) begin
        txd_next = tx_sh_reg[0];
        tx_sh_next = {1'b0, tx_sh_reg[7:1]};
        tx_cnt_next = 4'h0;
        tx_st_next = st_data;
      end
      st_data: if (tx_bit_end) begin
        if (tx_cnt_reg == last_data_idx) begin
          // parity bit only when enabled, else straight to stop
          if (ctl1_reg[ctl1_parity_enable]) begin
            txd_next = tx_par_reg;
            tx_st_next = st_parity;
          end else begin
            txd_next = 1'b1;
            tx_st_next = st_stop;
          end
        end else begin
          txd_next = tx_sh_reg[0];
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          tx_cnt_next = tx_cnt_reg + 4'h1;
        end
      end
      st_parity: if (tx_bit_end) begin
        txd_next = 1'b1;
        tx_st_next = st_stop;
      end
      st_stop: if (tx_bit_end) begin
        if (tx_stop2_reg) begin
          tx_stop2_next = 1'b0;
        end else begin
          tx_st_next = st_idle;
        end
      end
      default: tx_st_next = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_st_reg <= st_idle;
      tx_sh_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      tx_stop2_reg <= 1'b0;
      tx_par_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_stop2_reg <= tx_stop2_next;
      tx_par_reg <= tx_par_next;
      txd_reg <= txd_next;
    end
  end
  assign txd = txd_reg;

  // receive framer, single sample at mid-bit; no majority vote or error flags
  assign rx_restart = rx_st_reg == st_idle && ctl1_reg[ctl1_rx_enable]
    && rxd_prev_reg && !rxd;
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_stop2_next = rx_stop2_reg;
    rx_data_next = rx_data_reg;
    rx_full_next = rx_full_reg;
    if (rx_take) begin
      rx_full_next = 1'b0;
    end
    unique case (rx_st_reg)
      st_idle: if (rx_restart) begin
        rx_stop2_next = ctl1_reg[ctl1_stop_length];
        rx_cnt_next = 4'h0;
        rx_st_next = st_start;
      end
      st_start: begin
        // a high start sample is noise; drop back to idle
        if (rx_sample && rxd) begin
          rx_st_next = st_idle;
        end else if (rx_bit_end) begin
          rx_st_next = st_data;
        end
      end
      st_data: begin
        if (rx_sample) begin
          rx_sh_next = {rxd, rx_sh_reg[7:1]};
        end
        if (rx_bit_end) begin
          if (rx_cnt_reg == last_data_idx) begin
            rx_st_next = ctl1_reg[ctl1_parity_enable] ? st_parity : st_stop;
          end else begin
            rx_cnt_next = rx_cnt_reg + 4'h1;
          end
        end
      end
      st_parity: if (rx_bit_end) begin
        rx_st_next = st_stop;
      end
      st_stop: if (rx_bit_end) begin
        if (rx_stop2_reg) begin
          rx_stop2_next = 1'b0;
        end else begin
          // new byte wins over a same-cycle read of the old one
          rx_data_next = rx_sh_reg;
          rx_full_next = 1'b1;
          rx_st_next = st_idle;
        end
      end
      default: rx_st_next = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_reg <= st_idle;
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_stop2_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rxd_prev_reg <= 1'b1;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_sh_reg <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_stop2_reg <= rx_stop2_next;
      rx_data_reg <= rx_data_next;
      rx_full_reg <= rx_full_next;
      rxd_prev_reg <= rxd;
    end
  end

  a_start_low: assert property (@(posedge clk) disable iff (reset)
    tx_go |=> tx_st_reg == st_start && !txd) else $error("start bit not driven low");
  a_stop_high: assert property (@(posedge clk) disable iff (reset)
    tx_st_reg == st_stop |-> txd) else $error("stop bit not high");
  a_parity_skip: assert property (@(posedge clk) disable iff (reset)
    tx_st_reg == st_data && tx_bit_end && tx_cnt_reg == last_data_idx
    && !ctl1_reg[ctl1_parity_enable] |=> tx_st_reg == st_stop)
    else $error("parity sent while disabled");
  a_shared_timing: assert property (@(posedge clk) disable iff (reset)
    tim_if.divisor == divisor_reg && tim_if.tick_select == ctl2_reg)
    else $error("paths not sharing timing settings");
  a_rx_load: assert property (@(posedge clk) disable iff (reset)
    rx_st_reg == st_stop && rx_bit_end && !rx_stop2_reg |=> rx_full_reg)
    else $error("received byte not flagged");
endmodule

// ---- rtl/baud_pkg.sv ----
// constants, register map and types for the baud and bit timing block
package baud_pkg;
  localparam int unsigned divisor_width = 8;
  localparam logic [7:0] divisor_reset = 8'h00;
  // register byte offsets
  localparam logic [7:0] off_control_one = 8'h00;
  localparam logic [7:0] off_control_two = 8'h04;
  localparam logic [7:0] off_divisor = 8'h08;
  localparam logic [7:0] off_tx_data = 8'h0C;
  localparam logic [7:0] off_status = 8'h10;
  localparam logic [7:0] off_rx_data = 8'h14;
  // serial_control_one fields
  localparam int unsigned ctl1_tx_enable = 0;
  localparam int unsigned ctl1_rx_enable = 1;
  localparam int unsigned ctl1_parity_enable = 2;
  localparam int unsigned ctl1_parity_odd = 3;
  localparam int unsigned ctl1_stop_length = 4;
  localparam int unsigned ctl1_src_lo = 5;
  localparam int unsigned ctl1_src_hi = 6;
  // serial_control_two fields
  localparam int unsigned ctl2_tick_lo = 0;
  localparam int unsigned ctl2_tick_hi = 2;
  // status fields
  localparam int unsigned stat_tx_busy = 0;
  localparam int unsigned stat_rx_busy = 1;
  localparam int unsigned stat_rx_full = 2;
  // tick-count select encodings
  localparam logic [2:0] sel_16 = 3'h0;
  localparam logic [2:0] sel_16_17 = 3'h1;
  localparam logic [2:0] sel_15 = 3'h2;
  localparam logic [2:0] sel_15_16 = 3'h3;
  localparam logic [2:0] sel_17 = 3'h4;
  // last tick index of a bit (ticks minus one)
  localparam logic [4:0] last_15 = 5'h0E;
  localparam logic [4:0] last_16 = 5'h0F;
  localparam logic [4:0] last_17 = 5'h10;
  localparam logic [4:0] mid_tick = 5'h07;
  localparam int unsigned data_bits = 8;
  localparam logic [3:0] last_data_idx = 4'h7;
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_start = 5'b00010,
    st_data = 5'b00100,
    st_parity = 5'b01000,
    st_stop = 5'b10000
  } frame_state_t;
endpackage

// ---- rtl/bit_timing_if.sv ----
// timing settings shared between the top and the bit timer
`timescale 1ns/10ps
interface bit_timing_if;
  logic [7:0] divisor;
  logic [2:0] tick_select;
  logic src_tick;
  modport cfg(output divisor, output tick_select, output src_tick);
  modport timer(input divisor, input tick_select, input src_tick);
endinterface

// ---- rtl/bit_timer.sv ----
// sub-bit tick divider and per-bit tick counter for one serial path
`timescale 1ns/10ps
module bit_timer (
  input wire clk,
  input wire reset,
  bit_timing_if.timer cfg,
  input wire logic restart,
  output logic tick,
  output logic sample,
  output logic bit_end
);
  import baud_pkg::*;
  logic [7:0] div_reg, div_next;
  logic [4:0] idx_reg, idx_next;
  logic phase_reg, phase_next;

  // ticks of the current bit; phase 0 takes the smaller count
  function automatic logic [4:0] bit_last(input logic [2:0] sel, input logic ph);
    unique case (sel)
      sel_16: bit_last = last_16;
      sel_16_17: bit_last = ph ? last_17 : last_16;
      sel_15: bit_last = last_15;
      sel_15_16: bit_last = ph ? last_16 : last_15;
      sel_17: bit_last = last_17;
      default: bit_last = last_16;
    endcase
  endfunction

  assign tick = cfg.src_tick && (div_reg == cfg.divisor);
  assign sample = tick && (idx_reg == mid_tick);
  assign bit_end = tick && (idx_reg == 5'h00);

  // divider, down counter and alternation phase
  always_comb begin
    div_next = div_reg;
    idx_next = idx_reg;
    phase_next = phase_reg;
    if (restart) begin
      // frame start resets the phase so the start bit gets the short count
      div_next = 8'h00;
      phase_next = 1'b0;
      idx_next = bit_last(cfg.tick_select, 1'b0);
    end else if (cfg.src_tick) begin
      if (div_reg == cfg.divisor) begin
        div_next = 8'h00;
        if (idx_reg == 5'h00) begin
          phase_next = ~phase_reg;
          idx_next = bit_last(cfg.tick_select, ~phase_reg);
        end else begin
          idx_next = idx_reg - 5'h01;
        end
      end else begin
        div_next = div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 8'h00;
      idx_reg <= 5'h0F;
      phase_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      idx_reg <= idx_next;
      phase_reg <= phase_next;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (reset)
    tick && !restart && cfg.divisor == 8'h01 && cfg.src_tick
    ##1 cfg.src_tick && cfg.divisor == 8'h01
    |-> !tick) else $error("tick repeated before divisor elapsed");
  a_index_down: assert property (@(posedge clk) disable iff (reset)
    tick && !restart && idx_reg != 5'h00 |=> idx_reg == $past(idx_reg) - 5'h01)
    else $error("tick index not counting down");
  a_restart_phase: assert property (@(posedge clk) disable iff (reset)
    restart |=> phase_reg == 1'b0 && div_reg == 8'h00)
    else $error("frame start did not reset timing");
  a_alt_swap: assert property (@(posedge clk) disable iff (reset)
    bit_end && !restart |=> phase_reg != $past(phase_reg))
    else $error("alternation phase not swapped");
  a_index_range: assert property (@(posedge clk) disable iff (reset)
    idx_reg <= last_17) else $error("tick index above 16");
  a_select_16: assert property (@(posedge clk) disable iff (reset)
    bit_end && !restart && cfg.tick_select == sel_16 |=> idx_reg == last_16)
    else $error("select 000 did not load 16 ticks");
endmodule

// ---- tb/serial_peer.sv ----
// far-end serial device that sends frames into the receiver
`timescale 1ns/10ps
module serial_peer (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic [2:0] sel,
  input wire logic pe,
  input wire logic odd,
  input wire logic two_stop,
  input wire logic [31:0] unit,
  output logic rxd,
  output logic busy
);
  import baud_pkg::*;
  int n;
  // ticks in bit k; alternating modes give the start bit the smaller count
  function automatic int ticks_for(input logic [2:0] m, input int k);
    case (m)
      sel_16_17: return k[0] ? 17 : 16;
      sel_15: return 15;
      sel_15_16: return k[0] ? 16 : 15;
      sel_17: return 17;
      default: return 16;
    endcase
  endfunction
  // line level of bit k: start, data lsb first, parity, stops
  function automatic logic level_for(input int k, input logic [7:0] d, input logic p,
                                     input logic o);
    if (k == 0) return 1'b0;
    if (k <= 8) return d[k-1];
    if (k == 9 && p) return ^d ^ o;
    return 1'b1;
  endfunction
  // same rate as the device, so the rate error stays well inside the band
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (send) begin
        busy <= 1'b1;
        n = 10 + int'(pe) + int'(two_stop);
        for (int k = 0; k < n; k++) begin
          rxd <= level_for(k, data, pe, odd);
          repeat (ticks_for(sel, k) * unit) @(posedge clk);
        end
        rxd <= 1'b1; // line idles at mark
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/uart_baud_bit_timing_tb.sv ----
// self-checking bench for the baud and bit timing block
`timescale 1ns/10ps
module uart_baud_bit_timing_tb;
  import baud_pkg::*;
  logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, txd, rxd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, src;
  logic [2:0] hsize, src_ticks, m, psel;
  logic send, pe, odd, st2, peer_busy, p, o, s2;
  logic [7:0] pdata, dv, b;
  int unsigned punit;
  int num_errors, total_checks, unit, w;
  int scnt = 0;

  assign hready = hreadyout;

  uart_baud_bit_timing uart_baud_bit_timing_inst (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .src_ticks(src_ticks),
    .txd(txd),
    .rxd(rxd)
  );

  serial_peer peer_inst (
    .clk(clk),
    .send(send),
    .data(pdata),
    .sel(psel),
    .pe(pe),
    .odd(odd),
    .two_stop(st2),
    .unit(punit),
    .rxd(rxd),
    .busy(peer_busy)
  );

  always #5 clk = ~clk;

  // source strobes every 2, 3 and 4 cycles, so source lengths are exact
  always @(posedge clk) begin
    scnt <= (scnt == 11) ? 0 : scnt + 1;
    src_ticks <= {scnt % 4 == 3, scnt % 3 == 2, scnt % 2 == 1};
  end

  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (hready !== 1'b1 && w < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      w++;
    end while (hready !== 1'b1 && w < 100);
    rd = hrdata;
    if (w >= 50)
      num_errors++;
  endtask

  // walks a frame on txd; exact edges on the system clock, mid-bit otherwise
  task automatic check_frame(input bit strict);
    int len;
    logic e;
    for (int k = 0; k < 10 + int'(p) + int'(s2); k++) begin
      len = peer_inst.ticks_for(m, k) * unit;
      e = peer_inst.level_for(k, b, p, o);
      if (strict) begin
        #1;
        chk({31'h0, e}, {31'h0, txd}, "txd bit start");
        repeat (len - 1) @(posedge clk);
        #1;
        chk({31'h0, e}, {31'h0, txd}, "txd bit end");
        @(posedge clk);
      end else begin
        repeat (len / 2) @(posedge clk);
        #1;
        chk({31'h0, e}, {31'h0, txd}, "txd bit middle");
        repeat (len - len / 2) @(posedge clk);
      end
    end
  endtask

  // hang guard: the whole run needs well under a third of this
  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    send = 1'b0;
    pdata = 8'h00;
    psel = 3'h0;
    pe = 1'b0;
    odd = 1'b0;
    st2 = 1'b0;
    punit = 1;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(32'h752C));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values, including the unmapped word above rx data
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      chk(32'h0, rd, "reset value");
    end
    chk(32'h0, {31'h0, hresp}, "hresp okay");
    ahb(1'b1, off_control_one, 32'hFFFFFFFF);
    ahb(1'b0, off_control_one, 32'h0);
    chk(32'h0000007F, rd, "control one");
    ahb(1'b1, 8'h18, 32'hFFFFFFFF);
    ahb(1'b0, 8'h18, 32'h0);
    chk(32'h0, rd, "unmapped");
    // data written with the transmitter off must be dropped
    ahb(1'b1, off_control_one, 32'h0);
    ahb(1'b1, off_tx_data, 32'h000000A5);
    repeat (20) @(posedge clk);
    #1;
    chk(32'h1, {31'h0, txd}, "txd disabled");
    for (int it = 0; it < 8; it++) begin
      m = (it < 5) ? 3'(it) : 3'($urandom % 5);
      dv = (it == 0) ? 8'h00 : 8'($urandom % 3);
      src = (it < 5) ? 2'h0 : 2'(it - 4);
      {p, o, s2} = 3'($urandom);
      b = 8'($urandom);
      unit = (int'(dv) + 1) * ((src == 2'h0) ? 1 : int'(src) + 1);
      ahb(1'b1, off_control_one, {25'h0, src, s2, o, p, 2'h3});
      ahb(1'b1, off_control_two, {29'h0, m});
      ahb(1'b1, off_divisor, {24'h0, dv});
      ahb(1'b1, off_tx_data, {24'h0, b});
      // a write while busy must neither disturb nor queue behind the frame
      fork
        check_frame(src == 2'h0);
        if (it == 0) begin
          repeat (30) @(posedge clk);
          ahb(1'b1, off_tx_data, 32'h0000005A);
        end
      join
      repeat (3 * unit) @(posedge clk);
      #1;
      chk(32'h1, {31'h0, txd}, "txd after frame");
      // far end sends the same byte back at the same settings
      pdata <= b;
      psel <= m;
      pe <= p;
      odd <= o;
      st2 <= s2;
      punit <= unit;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (peer_busy === 1'b1 && w < 20000);
      if (w >= 20000)
        num_errors++;
      repeat (4) @(posedge clk);
      ahb(1'b0, off_status, 32'h0);
      chk(32'h00000004, rd, "status rx full");
      ahb(1'b0, off_rx_data, 32'h0);
      chk({24'h0, b}, rd, "rx data");
      // the full flag clears in the data phase, so a back-to-back status read is stale
      @(posedge clk);
      ahb(1'b0, off_status, 32'h0);
      chk(32'h0, rd, "status after read");
    end
    complete_run();
  end
endmodule
